// file: rtl/strap_config_regs.sv
// strap configuration register block: two read-only strap registers behind a simple port
`timescale 1ns/1ps
`default_nettype none
module strap_config_regs (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [31:0] sys_pin_in,
  input wire logic [31:0] sys_pin_pulldown,
  input wire logic [31:0] mem_pin_in,
  input wire logic [31:0] mem_pin_pulldown,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic clk_valid,
  output logic cache_valid,
  output logic cpu0_present,
  output logic cpu1_present
);
  logic [31:0] sys_strap, mem_strap;
  logic sys_done, mem_done;
  strap_cfg_pkg::sys_cfg_t sys_view;
  strap_cfg_pkg::decode_t dec_reg, dec_next;
  logic [31:0] rdata_reg, rdata_next;

  // one capture group per register; the two groups never share pins
  strap_capture u_sys (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in(sys_pin_in),
    .pin_pulldown(sys_pin_pulldown),
    .strap(sys_strap),
    .captured(sys_done)
  );

  strap_capture u_mem (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in(mem_pin_in),
    .pin_pulldown(mem_pin_pulldown),
    .strap(mem_strap),
    .captured(mem_done)
  );

  // identity and upper byte are fixed; only the field nibbles come from straps
  always_comb begin
    sys_view.kind = strap_cfg_pkg::system_kind_value;
    sys_view.clk = sys_strap[strap_cfg_pkg::clk_lsb +: 4];
    sys_view.cache = sys_strap[strap_cfg_pkg::cache_lsb +: 4];
    sys_view.cpu0 = sys_strap[strap_cfg_pkg::cpu0_lsb +: 4];
    sys_view.cpu1 = sys_strap[strap_cfg_pkg::cpu1_lsb +: 4];
    sys_view.upper = strap_cfg_pkg::upper_byte_value;
  end

  // decoded status for board logic; reserved codes read as invalid
  always_comb begin
    dec_next = dec_reg;
    if (sys_done) begin
      dec_next.clk_valid = sys_view.clk >= strap_cfg_pkg::clk_50_25;
      dec_next.cache_valid = sys_view.cache >= strap_cfg_pkg::cache_1m;
      // codes 4 to 7 mean a fitted part; 8 and up is an empty socket
      dec_next.cpu0_present = (sys_view.cpu0 >= strap_cfg_pkg::cpu_present_min)
                              && (sys_view.cpu0 < strap_cfg_pkg::cpu_absent_min);
      dec_next.cpu1_present = (sys_view.cpu1 >= strap_cfg_pkg::cpu_present_min)
                              && (sys_view.cpu1 < strap_cfg_pkg::cpu_absent_min);
    end
  end

  // writes are accepted and dropped: nothing here can alter the straps
  // wdata is never looked at, since the register has no writable bit
  always_comb begin
    rdata_next = strap_cfg_pkg::read_reset_value;
    if (rd_en) begin
      if (addr == strap_cfg_pkg::sys_cfg_offset) begin
        rdata_next = sys_view;
      end else if (addr == strap_cfg_pkg::mem_cfg_offset) begin
        rdata_next = mem_strap;
      end
    end
  end

  // reset wins over the clock enable so a power-up reset always lands
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_reg <= strap_cfg_pkg::read_reset_value;
      dec_reg <= '0;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
      dec_reg <= dec_next;
    end
  end

  // every output is a register: board logic never sees the read mux settle
  assign rdata = rdata_reg;
  assign clk_valid = dec_reg.clk_valid;
  assign cache_valid = dec_reg.cache_valid;
  assign cpu0_present = dec_reg.cpu0_present;
  assign cpu1_present = dec_reg.cpu1_present;

  // bus side: what each read answers, and the single cycle in which it stands
  a_sys_read_value: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && rd_en && addr == strap_cfg_pkg::sys_cfg_offset
    |=> rdata[7:0] == strap_cfg_pkg::system_kind_value && rdata[31:24] == 8'hff)
    else $error("system id or upper byte wrong");

  a_field_place: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && rd_en && addr == strap_cfg_pkg::sys_cfg_offset
    |=> rdata[23:8] == $past(sys_strap[23:8]))
    else $error("strap fields misplaced");

  a_mem_read: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && rd_en && addr == strap_cfg_pkg::mem_cfg_offset
    |=> rdata == $past(mem_strap))
    else $error("memory strap read wrong");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && rd_en && addr != strap_cfg_pkg::sys_cfg_offset && addr != strap_cfg_pkg::mem_cfg_offset
    |=> rdata == strap_cfg_pkg::read_reset_value)
    else $error("unmapped read not zero");

  a_idle_read_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !rd_en
    |=> rdata == strap_cfg_pkg::read_reset_value)
    else $error("read data outlived its cycle");

  a_write_ignored: assert property (@(posedge mclk) disable iff (!reset_n)
    sys_done && wr_en
    |=> $stable(sys_strap) && $stable(mem_strap))
    else $error("write changed straps");

  // clock enable low freezes the answers too, so a stalled master still sees its data
  a_freeze_rdata: assert property (@(posedge mclk) disable iff (!reset_n)
    !clk_en
    |=> $stable(rdata))
    else $error("read data moved while frozen");

  a_freeze_decode: assert property (@(posedge mclk) disable iff (!reset_n)
    !clk_en
    |=> $stable({clk_valid, cache_valid, cpu0_present, cpu1_present}))
    else $error("decode moved while frozen");

  // no disable here: the check must see the reset itself, a second power-up included
  a_reset_outputs: assert property (@(posedge mclk)
    !reset_n
    |=> rdata == strap_cfg_pkg::read_reset_value && sys_strap == strap_cfg_pkg::strap_reset_value
    && mem_strap == strap_cfg_pkg::strap_reset_value
    && !clk_valid && !cache_valid && !cpu0_present && !cpu1_present)
    else $error("reset values wrong");

  // capture side: one sample per power-up, pull-downs always win
  a_pullup_one: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(sys_done)
    |-> sys_strap == $past(sys_pin_in & ~sys_pin_pulldown))
    else $error("captured pattern wrong");

  a_mem_capture: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(mem_done)
    |-> mem_strap == $past(mem_pin_in & ~mem_pin_pulldown))
    else $error("memory pattern wrong");

  a_pulldown_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(mem_done)
    |-> (mem_strap & $past(mem_pin_pulldown)) == 32'h00000000)
    else $error("pulled-down pin not zero");

  a_sys_pulldown_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(sys_done)
    |-> (sys_strap & $past(sys_pin_pulldown)) == 32'h00000000)
    else $error("pulled-down system pin not zero");

  a_no_resample: assert property (@(posedge mclk) disable iff (!reset_n)
    sys_done && $past(sys_done)
    |-> $stable(sys_strap))
    else $error("system strap resampled");

  a_mem_no_resample: assert property (@(posedge mclk) disable iff (!reset_n)
    mem_done && $past(mem_done)
    |-> $stable(mem_strap))
    else $error("memory strap resampled");

  // decode side: reserved codes read invalid, and nothing decodes before the capture
  a_decode_before_capture: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && !sys_done
    |=> $stable({clk_valid, cache_valid, cpu0_present, cpu1_present}))
    else $error("decode moved before capture");

  a_clk_decode: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && sys_done
    |=> clk_valid == ($past(sys_strap[11:8]) >= 4'hd))
    else $error("clock decode wrong");

  a_cache_decode: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && sys_done
    |=> cache_valid == ($past(sys_strap[15:12]) >= 4'hc))
    else $error("cache decode wrong");

  a_cpu_decode: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && sys_done
    |=> cpu0_present == ($past(sys_strap[19:18]) == 2'b01))
    else $error("cpu0 decode wrong");

  a_cpu1_decode: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en && sys_done
    |=> cpu1_present == ($past(sys_strap[23:22]) == 2'b01))
    else $error("cpu1 decode wrong");
endmodule : strap_config_regs
`default_nettype wire

// file: rtl/strap_cfg_pkg.sv
// package: offsets, field layout, reset values and decoded field types for the strap configuration block
package strap_cfg_pkg;
  localparam logic [31:0] sys_cfg_offset = 32'hfef80400;
  localparam logic [31:0] mem_cfg_offset = 32'hfef80404;
  localparam logic [7:0] system_kind_value = 8'h5a; // arbitrary neutral identification value
  localparam logic [7:0] upper_byte_value = 8'hff;
  localparam int kind_lsb = 0;
  localparam int clk_lsb = 8;
  localparam int cache_lsb = 12;
  localparam int cpu0_lsb = 16;
  localparam int cpu1_lsb = 20;
  localparam int upper_lsb = 24;
  localparam logic [31:0] strap_reset_value = 32'hffffffff;
  localparam logic [31:0] read_reset_value = 32'h00000000;
  localparam logic [3:0] clk_50_25 = 4'hd;
  localparam logic [3:0] clk_60_30 = 4'he;
  localparam logic [3:0] clk_66_33 = 4'hf;
  localparam logic [3:0] cache_1m = 4'hc;
  localparam logic [3:0] cache_512k = 4'hd;
  localparam logic [3:0] cache_256k = 4'he;
  localparam logic [3:0] cache_none = 4'hf;
  localparam logic [3:0] cpu_present_min = 4'h4;
  localparam logic [3:0] cpu_absent_min = 4'h8;

  typedef struct packed {
    logic [7:0] upper;
    logic [3:0] cpu1;
    logic [3:0] cpu0;
    logic [3:0] cache;
    logic [3:0] clk;
    logic [7:0] kind;
  } sys_cfg_t;

  typedef struct packed {
    logic clk_valid;
    logic cache_valid;
    logic cpu0_present;
    logic cpu1_present;
  } decode_t;

  typedef enum logic [1:0] {
    st_wait = 2'b00,
    st_capture = 2'b01,
    st_hold = 2'b10
  } capture_state_t;
endpackage : strap_cfg_pkg

// file: rtl/strap_capture.sv
// strap capture: samples one 32-pin group once after power-up reset release, then holds it
`timescale 1ns/1ps
`default_nettype none
module strap_capture (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_pulldown,
  output logic [31:0] strap,
  output logic captured
);
  logic [31:0] strap_reg, strap_next;
  strap_cfg_pkg::capture_state_t state_reg, state_next;
  logic [31:0] pin_level;

  // weak pull-up: an undriven pin reads 1, only a pull-down strap gives 0
  assign pin_level = pin_in & ~pin_pulldown;

  always_comb begin
    strap_next = strap_reg;
    state_next = state_reg;
    unique case (state_reg)
      strap_cfg_pkg::st_wait: state_next = strap_cfg_pkg::st_capture;
      strap_cfg_pkg::st_capture: begin
        strap_next = pin_level; // second clocked edge after reset release; the first one leaves st_wait
        state_next = strap_cfg_pkg::st_hold;
      end
      strap_cfg_pkg::st_hold: state_next = strap_cfg_pkg::st_hold; // no resample
      default: state_next = strap_cfg_pkg::st_hold;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      strap_reg <= strap_cfg_pkg::strap_reset_value;
      state_reg <= strap_cfg_pkg::st_wait;
    end else if (clk_en) begin
      strap_reg <= strap_next;
      state_reg <= state_next;
    end
  end

  assign strap = strap_reg;
  assign captured = (state_reg == strap_cfg_pkg::st_hold);

  a_hold_stable: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(captured) && captured |-> $stable(strap_reg))
    else $error("strap changed after capture");
endmodule : strap_capture
`default_nettype wire

// file: dv/strap_board.sv
// board strap model: optional pull-down resistors on one 32-pin strap group
`timescale 1ns/1ps
`default_nettype none
module strap_board (
  input wire logic [31:0] fitted,
  output logic [31:0] pin_in,
  output logic [31:0] pin_pulldown
);
  // a pin without a resistor sits at the weak pull-up level; a fitted one is pulled low
  assign pin_pulldown = fitted;
  assign pin_in = ~fitted;
endmodule : strap_board
`default_nettype wire

// file: dv/strap_config_regs_bench.sv
// testbench: strap capture, read-only access, hold and field decodes of the strap registers
`timescale 1ns/1ps
`default_nettype none
module strap_config_regs_bench;
  logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [31:0] sys_fit = 32'h0, mem_fit = 32'h0, addr = 32'h0, wdata = 32'h0, rdata;
  logic [31:0] sys_pin_in, sys_pin_pulldown, mem_pin_in, mem_pin_pulldown;
  logic clk_valid, cache_valid, cpu0_present, cpu1_present;
  int err_total = 0;
  int n_compared = 0;
  localparam logic [31:0] sys_a = strap_cfg_pkg::sys_cfg_offset;
  localparam logic [31:0] mem_a = strap_cfg_pkg::mem_cfg_offset;
  always #2.5 mclk = ~mclk;
  strap_board sys_board_i (.fitted(sys_fit), .pin_in(sys_pin_in), .pin_pulldown(sys_pin_pulldown));
  strap_board mem_board_i (.fitted(mem_fit), .pin_in(mem_pin_in), .pin_pulldown(mem_pin_pulldown));
  strap_config_regs strap_config_regs_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .sys_pin_in(sys_pin_in), .sys_pin_pulldown(sys_pin_pulldown), .mem_pin_in(mem_pin_in),
    .mem_pin_pulldown(mem_pin_pulldown), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .clk_valid(clk_valid), .cache_valid(cache_valid), .cpu0_present(cpu0_present),
    .cpu1_present(cpu1_present));
  task conclude;
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  task rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  // board values are given as wanted pin levels; resistors go where a zero is wanted
  task power_up(input logic [31:0] sys_want, input logic [31:0] mem_want);
    @(posedge mclk);
    sys_fit <= ~sys_want;
    mem_fit <= ~mem_want;
    reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask : power_up
  function automatic logic [31:0] sys_exp(input logic [31:0] w);
    return {strap_cfg_pkg::upper_byte_value, w[23:8], strap_cfg_pkg::system_kind_value};
  endfunction : sys_exp
  task t_capture;
    logic [31:0] d;
    power_up(32'h12f84fd0, 32'ha5c3_0ff0);
    rd(sys_a, d);
    chk("sys read", sys_exp(32'h12f84fd0), d);
    #5 chk("rdata after read", 32'h0, rdata);
    rd(mem_a, d);
    chk("mem read", 32'ha5c30ff0, d);
    rd(32'hfef80408, d);
    chk("unmapped read", 32'h0, d);
    chk("decodes", 32'h8, {28'h0, clk_valid, cache_valid, cpu0_present, cpu1_present});
  endtask : t_capture
  task t_readonly;
    logic [31:0] d;
    wr(sys_a, 32'h0);
    wr(mem_a, 32'h0);
    rd(sys_a, d);
    chk("sys after write", sys_exp(32'h12f84fd0), d);
    rd(mem_a, d);
    chk("mem after write", 32'ha5c30ff0, d);
  endtask : t_readonly
  task t_hold;
    logic [31:0] d;
    @(posedge mclk);
    sys_fit <= 32'h0;
    mem_fit <= 32'hffffffff;
    repeat (20) @(posedge mclk);
    rd(sys_a, d);
    chk("sys held", sys_exp(32'h12f84fd0), d);
    rd(mem_a, d);
    chk("mem held", 32'ha5c30ff0, d);
  endtask : t_hold
  // a read answer must stand for as long as the clock enable is held low
  task t_freeze;
    @(posedge mclk);
    addr <= mem_a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    clk_en <= 1'b0;
    repeat (5) @(posedge mclk);
    #1 chk("rdata frozen", 32'ha5c30ff0, rdata);
    chk("decodes frozen", 32'h8, {28'h0, clk_valid, cache_valid, cpu0_present, cpu1_present});
    @(posedge mclk);
    clk_en <= 1'b1;
    @(posedge mclk);
    #1 chk("rdata after thaw", 32'h0, rdata);
  endtask : t_freeze
  task t_codes;
    logic [3:0] c, x, p0, p1;
    logic [31:0] w, d;
    for (int i = 0; i < 4; i++) begin
      c = 4'hc + 4'(i);
      x = 4'hb + 4'(i);
      p0 = 4'h3 + 4'(2 * i);
      p1 = 4'h4 + 4'(4 * i);
      w = {8'h00, p1, p0, x, c, 8'h3c};
      power_up(w, ~w);
      rd(sys_a, d);
      chk("sys fields", sys_exp(w), d);
      chk("decodes", {28'h0, c >= 4'hd, x >= 4'hc, p0 inside {[4'h4:4'h7]}, p1 inside {[4'h4:4'h7]}},
        {28'h0, clk_valid, cache_valid, cpu0_present, cpu1_present});
    end
  endtask : t_codes
  initial begin
    t_capture();
    t_readonly();
    t_hold();
    t_freeze();
    t_codes();
    conclude();
  end
  initial begin
    #20000;
    err_total++;
    conclude();
  end
endmodule : strap_config_regs_bench
`default_nettype wire
